// File: src/pil_defines.svh
// Constants for the peripheral interrupt logic: source indices, widths,
// reset values and bit positions. Assumes a single 250 MHz clock domain.
`ifndef PIL_DEFINES_SVH
`define PIL_DEFINES_SVH

// Widths
`define PIL_NUM_SRC        30
`define PIL_VEC_W          5
`define PIL_NUM_EP         8
`define PIL_NUM_BUS        7
`define PIL_NUM_DMA        2
`define PIL_CNT_W          16
`define PIL_BYTE_W         8

// Interrupt vector codes, one per source or first code of a group (bus, endpoint IN, OUT); the code is also the bit index
`define PIL_SRC_I2C_TX     0
`define PIL_SRC_I2C_RX     1
`define PIL_SRC_CODEC_TX   2
`define PIL_SRC_CODEC_RX   3
`define PIL_SRC_EXT        4
`define PIL_SRC_DMA0       5
`define PIL_SRC_DMA1       6
`define PIL_SRC_BUS_BASE   7
`define PIL_SRC_EP_IN      14
`define PIL_SRC_EP_OUT     22

// Positions within the USB bus event group
`define PIL_BUS_RESET      0
`define PIL_BUS_SUSPEND    1
`define PIL_BUS_RESUME     2
`define PIL_BUS_SOF        3
`define PIL_BUS_PSEUDO_FRAME_FLAG       4
`define PIL_BUS_SETUP      5
`define PIL_BUS_SETUP_OVERWRITE_FLAG      6

// Reset values and the counter step
`define PIL_FLAG_RST       1'b0
`define PIL_PEND_RST       1'b0
`define PIL_IRQ_N_RST      1'b1
`define PIL_VEC_RST        5'h00
`define PIL_CNT_RST        16'h0000
`define PIL_CNT_ONE        16'h0001

`endif

// File: src/pil_pkg.sv
// Types shared by the peripheral interrupt logic files.
// Assumes pil_defines.svh is on the include path.
`include "pil_defines.svh"

package pil_pkg;
   typedef logic [`PIL_NUM_SRC-1:0] src_vec_t;
   typedef logic [`PIL_VEC_W-1:0]   vec_code_t;
   typedef logic [`PIL_NUM_EP-1:0]  ep_vec_t;
   typedef logic [`PIL_NUM_BUS-1:0] bus_vec_t;
   typedef logic [`PIL_NUM_DMA-1:0] dma_vec_t;
   typedef logic [`PIL_CNT_W-1:0]   pkt_cnt_t;
   typedef enum logic {DMA_IDLE, DMA_RUN} dma_state_t;
endpackage

// File: src/sticky_bit.sv
// One sticky bit: set by a hardware event, cleared by a strobe.
// Assumes set and clear come from logic on the same clock.
`timescale 1ns/10ps

module sticky_bit #(
   parameter logic RST_VAL = 1'b0
) (
   input  wire logic ref_clk_i, // 250 MHz clock
   input  wire logic rst_i,     // Async reset, active high
   input  wire logic set_i,     // Event, one-cycle pulse
   input  wire logic clr_i,     // Clear strobe, one-cycle pulse
   output logic      bit_o      // Held bit
);

   logic next_bit;

   // Set beats clear so an event arriving in the clear cycle survives
   assign next_bit = set_i | (bit_o & ~clr_i);

   // State bit
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         bit_o <= RST_VAL;
      end else begin
         bit_o <= next_bit;
      end
   end

endmodule

// File: src/ext_irq_sync.sv
// Synchroniser and falling-edge detector for the external interrupt pin.
// Assumes the pin is asynchronous to ref_clk_i and active low.
`timescale 1ns/10ps

module ext_irq_sync (
   input  wire logic ref_clk_i,  // 250 MHz clock
   input  wire logic rst_i,      // Async reset, active high
   input  wire logic ext_irq_n_i, // External interrupt pin, active low
   output logic      fall_o      // One-cycle pulse on a new low level
);

   logic meta_n;
   logic sync_n;
   logic last_n;

   // Two-stage synchroniser, then one stage of history; reset as idle high
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta_n <= 1'b1;
         sync_n <= 1'b1;
         last_n <= 1'b1;
      end else begin
         meta_n <= ext_irq_n_i;
         sync_n <= meta_n;
         last_n <= sync_n;
      end
   end

   // Only a high-to-low move counts, so a pin held low fires once
   assign fall_o = last_n & ~sync_n;

endmodule

// File: src/peripheral_interrupt_logic.sv
// Interrupt aggregation for the embedded MCU: I2C, codec port, external pin,
// DMA bulk OUT completion, USB endpoint and USB bus events.
// Assumes all strobes except the external pin come from logic on ref_clk_i.
// Codes double as pending bit indices.
`timescale 1ns/10ps
`include "pil_defines.svh"

module peripheral_interrupt_logic (
   input  wire logic                ref_clk_i,              // 250 MHz clock
   input  wire logic                rst_i,                  // Global reset, async, active high

   // I2C interface events
   input  wire logic                i2c_tx_wr_i,            // MCU wrote i2c_tx_data_reg
   input  wire logic                i2c_tx_done_i,          // Byte shifted onto the bus
   input  wire logic                i2c_rx_byte_i,          // Byte landed in i2c_rx_data_reg
   input  wire logic                i2c_rx_rd_i,            // MCU read i2c_rx_data_reg
   output logic                     i2c_tx_empty_flag_o,    // tx_empty_flag of i2c_ctrl_status_reg
   output logic                     i2c_rx_full_flag_o,     // rx_full_flag of i2c_ctrl_status_reg

   // Codec port secondary channel events
   input  wire logic                codec_tx_start_i,       // Address written with write direction
   input  wire logic                codec_tx_taken_i,       // Codec accepted the word
   input  wire logic                codec_rx_word_i,        // Secondary word received
   input  wire logic                codec_rx_rd_i,          // MCU read the received word
   output logic                     codec_tx_empty_flag_o,  // tx_empty_flag of codec_ctrl_status_reg
   output logic                     codec_rx_full_flag_o,   // rx_full_flag of codec_ctrl_status_reg
   input  wire logic [3:0]          periph_mask_i,          // 1 enables: i2c tx, i2c rx, codec tx, rx

   // External interrupt
   input  wire logic                ext_irq_n_i,            // ext_irq_n pin, active low
   input  wire logic                ext_irq_en_i,           // Enable bit of global_ctrl_reg

   // DMA bulk OUT software handshake
   input  wire pil_pkg::pkt_cnt_t   bulk_packet_count_i,    // bulk_packet_count_high/low joined
   input  wire pil_pkg::dma_vec_t   dma_sw_bulk_i,          // Channel in bulk OUT software handshake
   input  wire pil_pkg::dma_vec_t   dma_start_i,            // Arm channel, one-cycle pulse
   input  wire pil_pkg::dma_vec_t   dma_pkt_done_i,         // Bulk OUT packet handled
   output pil_pkg::dma_vec_t        dma_run_o,              // Channel still running

   // USB endpoints
   input  wire pil_pkg::ep_vec_t    ep_in_ok_i,             // IN transaction succeeded
   input  wire pil_pkg::ep_vec_t    ep_out_ok_i,            // OUT transaction succeeded
   input  wire pil_pkg::ep_vec_t    ep_in_mask_i,           // 1 enables IN endpoint interrupt
   input  wire pil_pkg::ep_vec_t    ep_out_mask_i,          // 1 enables OUT endpoint interrupt
   output pil_pkg::ep_vec_t         ep_in_status_o,         // Read-only IN status
   output pil_pkg::ep_vec_t         ep_out_status_o,        // Read-only OUT status

   // USB bus events: reset, suspend, resume, sof, pseudo sof, setup
   input  wire logic [5:0]          usb_bus_evt_i,          // One-cycle pulses, setup in bit 5
   input  wire pil_pkg::bus_vec_t   usb_bus_mask_i,         // 1 enables, overwrite in bit 6
   output pil_pkg::bus_vec_t        usb_bus_status_o,       // bus_reset_flag .. setup_overwrite_flag

   // Interrupt vector register
   input  wire logic                ivec_wr_i,              // MCU writes vector register
   input  wire pil_pkg::vec_code_t  ivec_code_i,            // Code of the source to clear
   output pil_pkg::vec_code_t       ivec_o,                 // Highest-priority pending code
   output logic                     mcu_irq_input_a_n_o     // Request to the MCU, active low
);
   import pil_pkg::*;

   // Source sets, clears and held pending bits
   src_vec_t   src_set;
   src_vec_t   src_clr;
   src_vec_t   src_pend;
   src_vec_t   src_en;
   src_vec_t   src_active;

   // Event helpers
   logic       ext_fall;
   logic       setup_pkt;
   logic       setup_held;
   dma_vec_t   dma_fire;

   // Next output values
   vec_code_t  next_ivec;
   logic       next_irq_n;

   // External pin: synchronise and catch each new low level
   // A pin low at reset release fires once
   ext_irq_sync u_ext_sync (
      .ref_clk_i   (ref_clk_i),
      .rst_i       (rst_i),
      .ext_irq_n_i (ext_irq_n_i),
      .fall_o      (ext_fall)
   );

   // I2C transmit-empty: write clears, shifted byte sets
   // Set wins over a same-cycle write
   sticky_bit #(.RST_VAL(`PIL_FLAG_RST)) u_i2c_txe (
      .ref_clk_i (ref_clk_i),
      .rst_i     (rst_i),
      .set_i     (i2c_tx_done_i),
      .clr_i     (i2c_tx_wr_i),
      .bit_o     (i2c_tx_empty_flag_o)
   );

   // I2C receive-full: byte in sets, MCU read clears
   sticky_bit #(.RST_VAL(`PIL_FLAG_RST)) u_i2c_rxf (
      .ref_clk_i (ref_clk_i),
      .rst_i     (rst_i),
      .set_i     (i2c_rx_byte_i),
      .clr_i     (i2c_rx_rd_i),
      .bit_o     (i2c_rx_full_flag_o)
   );

   // Codec transmit-empty: address write clears, codec taking the word sets
   sticky_bit #(.RST_VAL(`PIL_FLAG_RST)) u_codec_txe (
      .ref_clk_i (ref_clk_i),
      .rst_i     (rst_i),
      .set_i     (codec_tx_taken_i),
      .clr_i     (codec_tx_start_i),
      .bit_o     (codec_tx_empty_flag_o)
   );

   // Codec receive-full: word in sets, MCU read clears
   // Shaped like the I2C receive pair
   sticky_bit #(.RST_VAL(`PIL_FLAG_RST)) u_codec_rxf (
      .ref_clk_i (ref_clk_i),
      .rst_i     (rst_i),
      .set_i     (codec_rx_word_i),
      .clr_i     (codec_rx_rd_i),
      .bit_o     (codec_rx_full_flag_o)
   );

   // Setup packet splits into setup or overwrite depending on the held setup bit
   assign setup_pkt  = usb_bus_evt_i[`PIL_BUS_SETUP];
   assign setup_held = src_pend[`PIL_SRC_BUS_BASE + `PIL_BUS_SETUP];

   // Peripheral sources; the flags above are never touched by a vector clear
   assign src_set[`PIL_SRC_I2C_TX]   = i2c_tx_done_i;
   assign src_set[`PIL_SRC_I2C_RX]   = i2c_rx_byte_i;
   assign src_set[`PIL_SRC_CODEC_TX] = codec_tx_taken_i;
   assign src_set[`PIL_SRC_CODEC_RX] = codec_rx_word_i;
   assign src_set[`PIL_SRC_EXT]      = ext_fall;
   // Set by the channel logic below
   assign src_set[`PIL_SRC_DMA0]     = dma_fire[0];
   assign src_set[`PIL_SRC_DMA1]     = dma_fire[1];

   // USB bus events; a setup packet on a held setup bit becomes an overwrite
   // One-cycle pulses from the USB engine
   assign src_set[`PIL_SRC_BUS_BASE + `PIL_BUS_RESET]   = usb_bus_evt_i[`PIL_BUS_RESET];
   assign src_set[`PIL_SRC_BUS_BASE + `PIL_BUS_SUSPEND] = usb_bus_evt_i[`PIL_BUS_SUSPEND];
   assign src_set[`PIL_SRC_BUS_BASE + `PIL_BUS_RESUME]  = usb_bus_evt_i[`PIL_BUS_RESUME];
   assign src_set[`PIL_SRC_BUS_BASE + `PIL_BUS_SOF]     = usb_bus_evt_i[`PIL_BUS_SOF];
   assign src_set[`PIL_SRC_BUS_BASE + `PIL_BUS_PSEUDO_FRAME_FLAG]    = usb_bus_evt_i[`PIL_BUS_PSEUDO_FRAME_FLAG];
   assign src_set[`PIL_SRC_BUS_BASE + `PIL_BUS_SETUP]   = setup_pkt & ~setup_held;
   assign src_set[`PIL_SRC_BUS_BASE + `PIL_BUS_SETUP_OVERWRITE_FLAG]   = setup_pkt & setup_held;

   // Endpoint transactions, one source each
   assign src_set[`PIL_SRC_EP_IN  +: `PIL_NUM_EP] = ep_in_ok_i;
   assign src_set[`PIL_SRC_EP_OUT +: `PIL_NUM_EP] = ep_out_ok_i;

   // Mask bits, 1 lets the source reach the MCU
   assign src_en[`PIL_SRC_I2C_TX]   = periph_mask_i[0];
   assign src_en[`PIL_SRC_I2C_RX]   = periph_mask_i[1];
   assign src_en[`PIL_SRC_CODEC_TX] = periph_mask_i[2];
   assign src_en[`PIL_SRC_CODEC_RX] = periph_mask_i[3];
   assign src_en[`PIL_SRC_EXT]      = ext_irq_en_i;
   // Not maskable; an idle channel never fires
   assign src_en[`PIL_SRC_DMA0]     = 1'b1;
   assign src_en[`PIL_SRC_DMA1]     = 1'b1;
   assign src_en[`PIL_SRC_BUS_BASE +: `PIL_NUM_BUS] = usb_bus_mask_i;
   assign src_en[`PIL_SRC_EP_IN    +: `PIL_NUM_EP]  = ep_in_mask_i;
   assign src_en[`PIL_SRC_EP_OUT   +: `PIL_NUM_EP]  = ep_out_mask_i;

   // One pending bit per source, cleared only by writing its code
   // Codes 30 and 31 clear nothing
   generate
      for (genvar s = 0; s < `PIL_NUM_SRC; s++) begin : g_src
         assign src_clr[s] = ivec_wr_i & (ivec_code_i == vec_code_t'(s));
         sticky_bit #(.RST_VAL(`PIL_PEND_RST)) u_pend (
            .ref_clk_i (ref_clk_i),
            .rst_i     (rst_i),
            .set_i     (src_set[s]),
            .clr_i     (src_clr[s]),
            .bit_o     (src_pend[s])
         );
      end
   endgenerate

   // Masking gates the request and the vector; pending bits keep their state
   assign src_active = src_pend & src_en;

   // Read-only status views equal the pending bits, so they hold until cleared
   assign ep_in_status_o   = src_pend[`PIL_SRC_EP_IN  +: `PIL_NUM_EP];
   assign ep_out_status_o  = src_pend[`PIL_SRC_EP_OUT +: `PIL_NUM_EP];
   assign usb_bus_status_o = src_pend[`PIL_SRC_BUS_BASE +: `PIL_NUM_BUS];

   // DMA channels: count handled bulk OUT packets against the shared count
   generate
      for (genvar c = 0; c < `PIL_NUM_DMA; c++) begin : g_dma
         dma_state_t state;
         dma_state_t next_state;
         pkt_cnt_t   pkt_cnt;
         pkt_cnt_t   next_cnt;
         pkt_cnt_t   cnt_inc;
         logic       pkt_ok;
         logic       last_pkt;
         logic       fire;

         // Packets only count in software handshake bulk OUT mode
         // Count 0 or 1 stops on the first packet
         assign pkt_ok   = dma_pkt_done_i[c] & dma_sw_bulk_i[c];
         assign cnt_inc  = pkt_cnt + `PIL_CNT_ONE;
         assign last_pkt = pkt_ok & (cnt_inc >= bulk_packet_count_i);

         // Next state; a start while running rearms with a fresh count
         always_comb begin
            next_state = state;
            next_cnt   = pkt_cnt;
            fire       = 1'b0;
            case (state)
               DMA_IDLE: begin
                  // Ignored outside software mode
                  if (dma_start_i[c] & dma_sw_bulk_i[c]) begin
                     next_state = DMA_RUN;
                     next_cnt   = `PIL_CNT_RST;
                  end
               end
               DMA_RUN: begin
                  // Restart wins over a packet
                  if (dma_start_i[c]) begin
                     next_cnt = `PIL_CNT_RST;
                  end else if (last_pkt) begin
                     next_state  = DMA_IDLE;
                     next_cnt    = cnt_inc;
                     fire        = 1'b1;
                  end else if (pkt_ok) begin
                     next_cnt = cnt_inc;
                  end
               end
               default: begin
                  // Unused encodings fall back to idle
                  next_state = DMA_IDLE;
                  next_cnt   = `PIL_CNT_RST;
               end
            endcase
         end

         // Channel state registers
         always_ff @(posedge ref_clk_i or posedge rst_i) begin
            if (rst_i) begin
               state   <= DMA_IDLE;
               pkt_cnt <= `PIL_CNT_RST;
            end else begin
               state   <= next_state;
               pkt_cnt <= next_cnt;
            end
         end

         assign dma_run_o[c] = (state == DMA_RUN);
         // Completion pulse, one cycle
         assign dma_fire[c]  = fire;
      end
   endgenerate

   // Lowest code wins the vector; a fixed order keeps firmware dispatch simple
   // Masked sources never block others
   always_comb begin
      next_ivec = `PIL_VEC_RST;
      for (int i = `PIL_NUM_SRC - 1; i >= 0; i--) begin
         if (src_active[i]) begin
            next_ivec = vec_code_t'(i);
         end
      end
   end

   // All sources fold onto the one MCU input
   // Drops two edges after the last clear
   assign next_irq_n = ~(|src_active);

   // Registered request and vector; one cycle late but glitch free
   // Code and request move on one edge
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ivec_o              <= `PIL_VEC_RST;
         mcu_irq_input_a_n_o <= `PIL_IRQ_N_RST;
      end else begin
         ivec_o              <= next_ivec;
         mcu_irq_input_a_n_o <= next_irq_n;
      end
   end

endmodule

// File: verif/peripheral_interrupt_logic_monitor.sv
// Concurrent checks on the peripheral interrupt logic ports.
// Assumes one clock domain and the async active-high reset of the design.
`timescale 1ns/10ps
module peripheral_interrupt_logic_monitor
   import pil_pkg::*;
(
   input wire logic                ref_clk_i,           // Clock
   input wire logic                rst_i,               // Reset
   input wire logic                i2c_tx_wr_i,         // Tx write
   input wire logic                i2c_tx_done_i,       // Tx shifted
   input wire logic                i2c_rx_byte_i,       // Rx byte
   input wire logic                i2c_rx_rd_i,         // Rx read
   input wire logic                i2c_tx_empty_flag_o, // Tx empty
   input wire logic                i2c_rx_full_flag_o,  // Rx full
   input wire logic                ext_irq_n_i,         // Ext pin
   input wire logic                ext_irq_en_i,        // Ext enable
   input wire pil_pkg::pkt_cnt_t   bulk_packet_count_i, // Count
   input wire pil_pkg::dma_vec_t   dma_sw_bulk_i,       // Sw mode
   input wire pil_pkg::dma_vec_t   dma_start_i,         // Arm
   input wire pil_pkg::dma_vec_t   dma_pkt_done_i,      // Packet
   input wire pil_pkg::dma_vec_t   dma_run_o,           // Running
   input wire pil_pkg::ep_vec_t    ep_in_mask_i,        // In mask
   input wire pil_pkg::ep_vec_t    ep_in_status_o,      // In status
   input wire pil_pkg::bus_vec_t   usb_bus_status_o,    // Bus status
   input wire logic                ivec_wr_i,           // Vector write
   input wire pil_pkg::vec_code_t  ivec_code_i,         // Clear code
   input wire logic                mcu_irq_input_a_n_o  // Request
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);

   // Flag behaviour of the I2C pair; a vector write must not touch flags
   tx_set_a: assert property (i2c_tx_done_i |=> i2c_tx_empty_flag_o) else $error("tx flag not set");
   tx_drop_a: assert property (i2c_tx_wr_i && !i2c_tx_done_i |=> !i2c_tx_empty_flag_o)
      else $error("tx flag not dropped");
   tx_keep_a: assert property (ivec_wr_i && !i2c_tx_wr_i && !i2c_tx_done_i |=> $stable(i2c_tx_empty_flag_o))
      else $error("tx flag moved on clear");
   rx_set_a: assert property (i2c_rx_byte_i |=> i2c_rx_full_flag_o) else $error("rx flag not set");
   rx_drop_a: assert property (i2c_rx_rd_i && !i2c_rx_byte_i |=> !i2c_rx_full_flag_o)
      else $error("rx flag not dropped");
   // Status bits only fall through a vector write
   ep_hold_a: assert property (!ivec_wr_i |=> (ep_in_status_o & $past(ep_in_status_o)) == $past(ep_in_status_o))
      else $error("endpoint status lost");
   bus_hold_a: assert property (!ivec_wr_i |=> (usb_bus_status_o & $past(usb_bus_status_o)) == $past(usb_bus_status_o))
      else $error("bus status lost");
   ep_irq_a: assert property (|(ep_in_status_o & ep_in_mask_i) |=> !mcu_irq_input_a_n_o)
      else $error("no request for endpoint");
   // Channel 1 is run with a count of one, so one packet ends it
   dma_arm_a: assert property (dma_start_i[1] && dma_sw_bulk_i[1] |=> dma_run_o[1])
      else $error("dma not armed");
   dma_stop_a: assert property (
      dma_run_o[1] && dma_pkt_done_i[1] && dma_sw_bulk_i[1] && !dma_start_i[1]
      && bulk_packet_count_i <= 16'h0001 |=> !dma_run_o[1]) else $error("dma not stopped");
   // Sync chain needs a few edges, so allow five before the request
   ext_irq_a: assert property (
      ext_irq_en_i && $fell(ext_irq_n_i) ##1 (!ext_irq_n_i && !ivec_wr_i && ext_irq_en_i)[*4]
      |=> !mcu_irq_input_a_n_o) else $error("ext pin not seen");
   setup_ow_c: cover property (usb_bus_status_o[6]);
   dma_run_c: cover property (!dma_run_o[0] ##1 dma_run_o[0]);
   clr_c: cover property (ivec_wr_i && ivec_code_i == 5'h0C);
endmodule

bind peripheral_interrupt_logic peripheral_interrupt_logic_monitor mon (.*);

// File: verif/fw_model.sv
// Firmware model behind the MCU interrupt input: services the request by
// writing the reported code to the vector register, one code at a time.
// Assumes the request follows a clear two edges later.
`timescale 1ns/10ps
module fw_model
   import pil_pkg::*;
(
   input  wire logic               ref_clk_i, // Clock
   input  wire logic               rst_i,     // Async reset, active high
   input  wire logic               en_i,      // Servicing enabled
   input  wire logic               irq_n_i,   // Request, active low
   input  wire pil_pkg::vec_code_t vec_i,     // Pending code
   output logic                    wr_o,      // Vector write strobe
   output pil_pkg::vec_code_t      code_o,    // Code to clear
   output logic [7:0]              served_o   // Count of services
);
   logic [2:0] hold;
   // Four idle cycles after each write, else a stale code is cleared twice
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         wr_o <= 1'b0;
         code_o <= 5'h00;
         served_o <= 8'h00;
         hold <= 3'h0;
      end else begin
         wr_o <= 1'b0;
         if (hold != 3'h0) begin
            hold <= hold - 3'h1;
         end else if (en_i && !irq_n_i) begin
            wr_o <= 1'b1;
            code_o <= vec_i;
            served_o <= served_o + 8'h01;
            hold <= 3'h4;
         end
      end
   end
endmodule

// File: verif/test_peripheral_interrupt_logic.sv
// Self-checking bench for peripheral_interrupt_logic with a firmware model.
// Assumes pil_pkg, the design and the model are compiled first.
`timescale 1ns/10ps
`include "pil_defines.svh"
module test_peripheral_interrupt_logic;
   import pil_pkg::*;
   logic        ref_clk_i, rst_i, ext_n, ext_en, tb_wr, fw_en, fw_wr, irq_n, tx_empty_flag, rx_full_flag, ctxe, crxf;
   logic [33:0] pv;
   logic [3:0]  pmask;
   logic [7:0]  served;
   logic [15:0] r;
   pkt_cnt_t    cnt;
   dma_vec_t    sw, run;
   ep_vec_t     inm, outm, ins, outs;
   bus_vec_t    busm, buss;
   vec_code_t   tb_code, fw_code, ivec;
   int          failures, n_checks, cyc, seed, i, n, m;

   // Pulse bits: 7:0 i2c/codec, 13:8 bus, 29:14 endpoints, 33:30 dma
   peripheral_interrupt_logic DUT (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .i2c_tx_wr_i(pv[0]),
      .i2c_tx_done_i(pv[1]), .i2c_rx_byte_i(pv[2]), .i2c_rx_rd_i(pv[3]), .i2c_tx_empty_flag_o(tx_empty_flag),
      .i2c_rx_full_flag_o(rx_full_flag), .codec_tx_start_i(pv[4]), .codec_tx_taken_i(pv[5]), .codec_rx_word_i(pv[6]),
      .codec_rx_rd_i(pv[7]), .codec_tx_empty_flag_o(ctxe), .codec_rx_full_flag_o(crxf), .periph_mask_i(pmask),
      .ext_irq_n_i(ext_n), .ext_irq_en_i(ext_en), .bulk_packet_count_i(cnt), .dma_sw_bulk_i(sw),
      .dma_start_i(pv[31:30]), .dma_pkt_done_i(pv[33:32]), .dma_run_o(run), .ep_in_ok_i(pv[21:14]),
      .ep_out_ok_i(pv[29:22]), .ep_in_mask_i(inm), .ep_out_mask_i(outm), .ep_in_status_o(ins),
      .ep_out_status_o(outs), .usb_bus_evt_i(pv[13:8]), .usb_bus_mask_i(busm), .usb_bus_status_o(buss),
      .ivec_wr_i(tb_wr | fw_wr), .ivec_code_i(fw_wr ? fw_code : tb_code), .ivec_o(ivec),
      .mcu_irq_input_a_n_o(irq_n));
   fw_model FW (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .en_i(fw_en), .irq_n_i(irq_n), .vec_i(ivec),
      .wr_o(fw_wr), .code_o(fw_code), .served_o(served));

   // Clock and hang guard; the whole run needs well under a thousand cycles
   initial begin
      ref_clk_i = 1'b0;
      forever #2 ref_clk_i = ~ref_clk_i;
   end
   always @(posedge ref_clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         report_and_stop;
      end
   end

   function automatic int ones(input logic [15:0] v);
      int k;
      ones = 0;
      for (k = 0; k < 16; k++) ones += v[k];
   endfunction

   task automatic report_and_stop;
      if (failures == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         failures++;
         $display("Error %s expected %0h seen %0h", nm, e, g);
      end
   endtask

   // One-cycle event, then wait until the request has had time to follow
   task automatic pulse(input int b);
      @(posedge ref_clk_i) pv[b] <= 1'b1;
      @(posedge ref_clk_i) pv[b] <= 1'b0;
      repeat (3) @(posedge ref_clk_i);
      #1;
   endtask

   task automatic clr(input int c);
      @(posedge ref_clk_i) tb_wr <= 1'b1;
      tb_code <= 5'(c);
      @(posedge ref_clk_i) tb_wr <= 1'b0;
      repeat (3) @(posedge ref_clk_i);
      #1;
   endtask

   task automatic wait_ck(input int k);
      repeat (k) @(posedge ref_clk_i);
      #1;
   endtask

   initial begin
      seed = 32'h26d72bc6;
      {rst_i, ext_n, ext_en, tb_wr, fw_en, pv, cnt, sw, tb_code} = '0;
      rst_i = 1'b1;
      ext_n = 1'b1;
      {ext_en, pmask, inm, outm, busm} = '1;
      repeat (2) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      wait_ck(1);
      chk("irq_n", 1, irq_n);
      pulse(1); chk("txe", 1, tx_empty_flag); chk("ivec", `PIL_SRC_I2C_TX, ivec); chk("irq_n", 0, irq_n);
      clr(0); chk("txe", 1, tx_empty_flag); chk("irq_n", 1, irq_n);
      pulse(0); chk("txe", 0, tx_empty_flag);
      pulse(2); chk("rxf", 1, rx_full_flag); chk("ivec", `PIL_SRC_I2C_RX, ivec);
      clr(1); chk("rxf", 1, rx_full_flag); pulse(3); chk("rxf", 0, rx_full_flag);
      @(posedge ref_clk_i) pmask <= 4'hB;
      pulse(5); chk("ctxe", 1, ctxe); chk("irq_n", 1, irq_n);
      @(posedge ref_clk_i) pmask <= 4'hF;
      wait_ck(2); chk("ivec", `PIL_SRC_CODEC_TX, ivec); clr(2); chk("ctxe", 1, ctxe);
      pulse(6);
      chk("crxf", 1, crxf);
      chk("ivec", `PIL_SRC_CODEC_RX, ivec);
      clr(3);
      chk("crxf", 1, crxf);
      pulse(7);
      chk("crxf", 0, crxf);
      pulse(4);
      chk("ctxe", 0, ctxe);
      // External pin: held low gives one interrupt, a new fall gives another
      @(posedge ref_clk_i) ext_n <= 1'b0;
      wait_ck(8); chk("ivec", `PIL_SRC_EXT, ivec); clr(4); wait_ck(10); chk("irq_n", 1, irq_n);
      @(posedge ref_clk_i) ext_n <= 1'b1;
      @(posedge ref_clk_i) ext_n <= 1'b0;
      wait_ck(8); chk("irq_n", 0, irq_n); clr(4);
      @(posedge ref_clk_i) ext_en <= 1'b0;
      ext_n <= 1'b1;
      @(posedge ref_clk_i) ext_n <= 1'b0;
      wait_ck(8); chk("irq_n", 1, irq_n);
      @(posedge ref_clk_i) ext_en <= 1'b1;
      wait_ck(3); chk("irq_n", 0, irq_n); clr(4);
      // DMA: channel 0 random count, channel 1 count of one
      for (i = 0; i < 2; i++) begin
         n = i ? 1 : 2 + ($unsigned($random(seed)) % 4);
         @(posedge ref_clk_i) cnt <= 16'(n);
         sw <= 2'b11;
         pulse(30 + i); chk("run", 1, run[i]);
         repeat (n - 1) pulse(32 + i);
         chk("run", 1, run[i]); pulse(32 + i); chk("run", 0, run[i]);
         chk("ivec", `PIL_SRC_DMA0 + i, ivec); clr(`PIL_SRC_DMA0 + i);
      end
      @(posedge ref_clk_i) sw <= 2'b00;
      pulse(30); chk("run", 0, run[0]);
      // Endpoints at random, masked or not
      for (i = 0; i < 8; i++) begin
         n = $unsigned($random(seed)) % 16;
         m = $unsigned($random(seed)) % 2;
         @(posedge ref_clk_i) {outm, inm} <= m ? 16'hFFFF : ~(16'h0001 << n);
         pulse(14 + n); chk("status", 1, {outs, ins} >> n); chk("irq_n", !m, irq_n);
         wait_ck(5); chk("status", 1, {outs, ins} >> n);
         clr(`PIL_SRC_EP_IN + n); chk("status", 0, {outs, ins});
      end
      @(posedge ref_clk_i) {outm, inm} <= 16'hFFFF;
      for (i = 0; i < 6; i++) begin
         pulse(8 + i); chk("bus", 1, buss[i]); chk("ivec", `PIL_SRC_BUS_BASE + i, ivec);
         clr(`PIL_SRC_BUS_BASE + i); chk("bus", 0, buss[i]);
      end
      @(posedge ref_clk_i) busm <= 7'h7E;
      pulse(8);
      chk("irq_n", 1, irq_n);
      chk("bus", 1, buss[0]);
      @(posedge ref_clk_i) busm <= 7'h7F;
      clr(7);
      pulse(13); pulse(13); chk("bus", 7'h60, buss);
      clr(12); clr(13);
      // Many sources at once, serviced by the firmware model
      r = 16'($random(seed)) | 16'h0001;
      @(posedge ref_clk_i) pv[29:14] <= r;
      @(posedge ref_clk_i) pv[29:14] <= 16'h0000;
      fw_en <= 1'b1;
      wait_ck(200); chk("served", ones(r), served); chk("irq_n", 1, irq_n);
      chk("status", 0, {outs, ins});
      fw_en <= 1'b0;
      pulse(1); pulse(14);
      @(posedge ref_clk_i) rst_i <= 1'b1;
      repeat (2) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      wait_ck(1); chk("txe", 0, tx_empty_flag); chk("status", 0, ins); chk("irq_n", 1, irq_n);
      report_and_stop;
   end
endmodule
